// ### logic/ufb_defines.svh
// register indices, field positions and packet constants for the usb endpoint logic
`ifndef UFB_DEFINES_SVH
`define UFB_DEFINES_SVH

// device word indices; byte address is four times the index
`define UFB_IDX_EP0_FIRST 8'h20
`define UFB_IDX_EP0_LAST 8'h27
`define UFB_IDX_EP1 8'h28
`define UFB_IDX_EP2 8'h30
`define UFB_IDX_CTRL 8'h38
`define UFB_IDX_FLAGS 8'h39
`define UFB_IDX_IEN 8'h3a
`define UFB_IDX_CLR 8'h3b

// device control bits
`define UFB_CTL_EP1_TXEN 0
`define UFB_CTL_EP2_TXEN 1
`define UFB_CTL_EP2_RXEN 2
`define UFB_CTL_SUSPEND 3
`define UFB_CTL_W 4

// flag, enable and clear bit positions
`define UFB_FLG_EP0_TX 0
`define UFB_FLG_EP1_TX 1
`define UFB_FLG_EP2_TX 2
`define UFB_FLG_EP2_RX 3
`define UFB_FLG_RESUME 4
`define UFB_NFLAGS 5

// packet geometry
`define UFB_PKT_BYTES 8
`define UFB_LAST_BYTE 3'h7

// endpoint numbers
`define UFB_EP0 2'h0
`define UFB_EP1 2'h1
`define UFB_EP2 2'h2

// host controller word indices and fields
`define UFB_H_IDX_CMD 8'h00
`define UFB_H_IDX_STAT 8'h01
`define UFB_H_IDX_TX 8'h08
`define UFB_H_IDX_RX 8'h10
`define UFB_CMD_PID 1:0
`define UFB_CMD_EP 3:2
`define UFB_CMD_GO 4
`define UFB_CMD_RESUME 5

`endif

// ### logic/ufb_device.sv
// usb function end: endpoint buffers, handshake flags and cpu register slave
// Behaviour
// - nak ep2 in while ep2 tx flag set
// - software sets ep2 tx enable before sending
// - ep2 tx flag reset clear, write ignored
// - set ep2 rx flag after acked out
// - ep2 rx flag cleared by clear bit
// - software sets ep2 rx enable for next
// - nak ep2 out while ep2 rx flag set
// - ep2 rx flag reset clear, write ignored
// - set ep1 tx flag after host ack
// - ep1 tx flag cleared by clear bit
// - software sets ep1 tx enable too
// - nak ep1 in while flag set
// - resume flag on activity while suspended
// - resume flag cleared only by clear bit
// - ep0 out/setup data into rx buffer
// - ep0 writes fill tx buffer, reset-free
// - ep1 write-only buffer sent on in
// - ep0 in completion sets ep0 tx flag
//
// The APB slave port was left to the implementer.
`timescale 1ns/100ps
`include "ufb_defines.svh"
module ufb_device (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// interrupt request
	output logic usb_irq,
	// usb link
	ufb_link_if.dev link
);
	logic [7:0] ep0_receive_buffer_q [`UFB_PKT_BYTES];
	logic [7:0] ep0_transmit_buffer_q [`UFB_PKT_BYTES];
	logic [7:0] ep1_transmit_buffer_q [`UFB_PKT_BYTES];
	logic [7:0] ep2_tx_buf_q [`UFB_PKT_BYTES];
	logic [7:0] ep2_rx_buf_q [`UFB_PKT_BYTES];
	logic [`UFB_CTL_W-1:0] ctl_q;
	logic [`UFB_NFLAGS-1:0] ien_q, flags, set_vec, clr_vec;
	logic [31:0] prdata_q, rd_mux;
	logic [7:0] widx, dd_data_q;
	logic [2:0] bsel, cnt_q;
	logic [1:0] ep_q;
	logic top_ok, hit_ep0, hit_ep1, hit_ep2, hit_ctl, hit_flg, hit_ien, hit_clr, mapped, wr_acc, rd_setup;
	logic irq_q, nak_q, in_nak, out_nak, tx_ack, rx2_ack, dd_valid_q, dd_last_q;
	ufb_pkg::ufb_dev_state_t state_q;
	ufb_pkg::ufb_hs_t hs_code_q;
	// address decode; the upper address bits must be zero
	assign widx = paddr[9:2];
	assign bsel = paddr[4:2];
	assign top_ok = (paddr[11:10] == 2'b00);
	assign hit_ep0 = top_ok && (widx >= `UFB_IDX_EP0_FIRST) && (widx <= `UFB_IDX_EP0_LAST);
	assign hit_ep1 = top_ok && ({widx[7:3], 3'b000} == `UFB_IDX_EP1);
	assign hit_ep2 = top_ok && ({widx[7:3], 3'b000} == `UFB_IDX_EP2);
	assign hit_ctl = top_ok && (widx == `UFB_IDX_CTRL);
	assign hit_flg = top_ok && (widx == `UFB_IDX_FLAGS);
	assign hit_ien = top_ok && (widx == `UFB_IDX_IEN);
	assign hit_clr = top_ok && (widx == `UFB_IDX_CLR);
	assign mapped = hit_ep0 | hit_ep1 | hit_ep2 | hit_ctl | hit_flg | hit_ien | hit_clr;
	assign wr_acc = psel & penable & pwrite & mapped;
	assign rd_setup = psel & ~penable & ~pwrite;

	// zero wait state; read data is captured in the setup cycle
	assign pready = psel & penable;
	assign pslverr = psel & penable & ~mapped;
	assign prdata = prdata_q;

	// read mux; the write-only ep1 buffer and the clear register read zero
	always_comb begin
		rd_mux = '0;
		if (hit_ep0) begin
			rd_mux[7:0] = ep0_receive_buffer_q[bsel];
		end else if (hit_ep2) begin
			rd_mux[7:0] = ep2_rx_buf_q[bsel];
		end else if (hit_ctl) begin
			rd_mux[`UFB_CTL_W-1:0] = ctl_q;
		end else if (hit_flg) begin
			rd_mux[`UFB_NFLAGS-1:0] = flags;
		end else if (hit_ien) begin
			rd_mux[`UFB_NFLAGS-1:0] = ien_q;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= '0;
		end else if (rd_setup) begin
			prdata_q <= rd_mux;
		end
	end

	// cpu side buffer loads; buffers keep their contents through reset
	always_ff @(posedge pclk) begin
		if (wr_acc && hit_ep0) ep0_transmit_buffer_q[bsel] <= pwdata[7:0];
		if (wr_acc && hit_ep1) ep1_transmit_buffer_q[bsel] <= pwdata[7:0];
		if (wr_acc && hit_ep2) ep2_tx_buf_q[bsel] <= pwdata[7:0];
	end

	// link side receive buffers; a naked packet leaves them untouched
	always_ff @(posedge pclk) begin
		if (state_q == ufb_pkg::DS_RX && link.hd_valid && !nak_q) begin
			if (ep_q == `UFB_EP0) begin
				ep0_receive_buffer_q[cnt_q] <= link.hd_data;
			end else begin
				ep2_rx_buf_q[cnt_q] <= link.hd_data;
			end
		end
	end

	// enables: software sets them, a completed packet drops them again
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctl_q <= '0;
		end else if (wr_acc && hit_ctl) begin
			ctl_q <= pwdata[`UFB_CTL_W-1:0];
		end else begin
			if (tx_ack && ep_q == `UFB_EP1) ctl_q[`UFB_CTL_EP1_TXEN] <= 1'b0;
			if (tx_ack && ep_q == `UFB_EP2) ctl_q[`UFB_CTL_EP2_TXEN] <= 1'b0;
			if (rx2_ack) ctl_q[`UFB_CTL_EP2_RXEN] <= 1'b0;
		end
	end
	// interrupt enables, software only
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ien_q <= '0;
		end else if (wr_acc && hit_ien) begin
			ien_q <= pwdata[`UFB_NFLAGS-1:0];
		end
	end

	// hardware events that set flags
	assign tx_ack = (state_q == ufb_pkg::DS_WACK) && link.hh_ack;
	assign rx2_ack = (state_q == ufb_pkg::DS_HS) && (hs_code_q == ufb_pkg::HSK_ACK) && (ep_q == `UFB_EP2);
	always_comb begin
		set_vec = '0;
		set_vec[`UFB_FLG_EP0_TX] = tx_ack && (ep_q == `UFB_EP0);
		set_vec[`UFB_FLG_EP1_TX] = tx_ack && (ep_q == `UFB_EP1);
		set_vec[`UFB_FLG_EP2_TX] = tx_ack && (ep_q == `UFB_EP2);
		set_vec[`UFB_FLG_EP2_RX] = rx2_ack;
		set_vec[`UFB_FLG_RESUME] = link.bus_act && ctl_q[`UFB_CTL_SUSPEND];
	end

	// only the clear register clears; the flag register ignores writes
	assign clr_vec = (wr_acc && hit_clr) ? pwdata[`UFB_NFLAGS-1:0] : '0;

	// one sticky cell per flag
	for (genvar i = 0; i < `UFB_NFLAGS; i++) begin : g_flag
		ufb_flag u_flag (
			.pclk(pclk),
			.presetn(presetn),
			.set(set_vec[i]),
			.clr(clr_vec[i]),
			.q(flags[i])
		);
	end

	// interrupt request from flip-flop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= |(flags & ien_q);
		end
	end
	assign usb_irq = irq_q;

	// answer decisions for a fresh token; endpoint 3 does not exist
	always_comb begin
		case (link.tok_ep)
			`UFB_EP0: in_nak = 1'b0;
			`UFB_EP1: in_nak = flags[`UFB_FLG_EP1_TX] | ~ctl_q[`UFB_CTL_EP1_TXEN];
			`UFB_EP2: in_nak = flags[`UFB_FLG_EP2_TX] | ~ctl_q[`UFB_CTL_EP2_TXEN];
			default: in_nak = 1'b1;
		endcase
		if (link.tok_ep == `UFB_EP0) begin
			out_nak = 1'b0;
		end else if (link.tok_ep == `UFB_EP2 && link.tok_pid == ufb_pkg::PID_OUT) begin
			out_nak = flags[`UFB_FLG_EP2_RX] | ~ctl_q[`UFB_CTL_EP2_RXEN];
		end else begin
			out_nak = 1'b1;
		end
	end

	// transaction sequencer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= ufb_pkg::DS_IDLE;
			ep_q <= '0;
			cnt_q <= '0;
			nak_q <= 1'b0;
			hs_code_q <= ufb_pkg::HSK_ACK;
		end else begin
			case (state_q)
				ufb_pkg::DS_IDLE: begin
					cnt_q <= '0;
					if (link.tok_valid) begin
						ep_q <= link.tok_ep;
						if (link.tok_pid == ufb_pkg::PID_IN) begin
							hs_code_q <= ufb_pkg::HSK_NAK;
							state_q <= in_nak ? ufb_pkg::DS_HS : ufb_pkg::DS_TX;
						end else begin
							nak_q <= out_nak;
							state_q <= ufb_pkg::DS_RX;
						end
					end
				end
				ufb_pkg::DS_RX: begin
					if (link.hd_valid) begin
						cnt_q <= cnt_q + 3'h1; // extra bytes wrap over the first ones
						if (link.hd_last) begin
							hs_code_q <= nak_q ? ufb_pkg::HSK_NAK : ufb_pkg::HSK_ACK;
							state_q <= ufb_pkg::DS_HS;
						end
					end
				end
				ufb_pkg::DS_HS: begin
					state_q <= ufb_pkg::DS_IDLE;
				end
				ufb_pkg::DS_TX: begin
					cnt_q <= cnt_q + 3'h1;
					if (cnt_q == `UFB_LAST_BYTE) begin
						state_q <= ufb_pkg::DS_WACK;
					end
				end
				ufb_pkg::DS_WACK: begin
					// a new token means the host gave up; the flag stays clear
					if (link.hh_ack || link.tok_valid) begin
						state_q <= ufb_pkg::DS_IDLE;
					end
				end
				default: begin
					state_q <= ufb_pkg::DS_IDLE;
				end
			endcase
		end
	end

	// in data path, one byte per cycle from the selected buffer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dd_valid_q <= 1'b0;
			dd_last_q <= 1'b0;
			dd_data_q <= '0;
		end else begin
			dd_valid_q <= (state_q == ufb_pkg::DS_TX);
			dd_last_q <= (state_q == ufb_pkg::DS_TX) && (cnt_q == `UFB_LAST_BYTE);
			if (state_q == ufb_pkg::DS_TX) begin
				case (ep_q)
					`UFB_EP0: dd_data_q <= ep0_transmit_buffer_q[cnt_q];
					`UFB_EP1: dd_data_q <= ep1_transmit_buffer_q[cnt_q];
					default: dd_data_q <= ep2_tx_buf_q[cnt_q];
				endcase
			end
		end
	end

	assign link.dd_valid = dd_valid_q;
	assign link.dd_last = dd_last_q;
	assign link.dd_data = dd_data_q;
	assign link.hs_valid = (state_q == ufb_pkg::DS_HS);
	assign link.hs_code = hs_code_q;
endmodule

// ### logic/ufb_flag.sv
// sticky status flag where a hardware set beats a software clear
`timescale 1ns/100ps
module ufb_flag (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// set and clear strobes
	input wire logic set,
	input wire logic clr,
	// flag
	output logic q
);
	logic flag_q;

	// set first so an event in the clearing cycle survives
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flag_q <= 1'b0;
		end else if (set) begin
			flag_q <= 1'b1;
		end else if (clr) begin
			flag_q <= 1'b0;
		end
	end

	assign q = flag_q;
endmodule

// ### logic/ufb_host.sv
// host controller end: issues tokens and data on the link from apb commands
`timescale 1ns/100ps
`include "ufb_defines.svh"
module ufb_host (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// usb link
	ufb_link_if.host link
);
	logic [7:0] tx_buf_q [`UFB_PKT_BYTES];
	logic [7:0] rx_buf_q [`UFB_PKT_BYTES];
	ufb_pkg::ufb_host_state_t state_q;
	ufb_pkg::ufb_pid_t pid_q;
	ufb_pkg::ufb_res_t res_q;
	logic [1:0] ep_q;
	logic [2:0] cnt_q;
	logic [7:0] hd_data_q;
	logic [31:0] prdata_q;
	logic [31:0] rd_mux;
	logic [7:0] widx;
	logic [2:0] bsel;
	logic hit_cmd;
	logic hit_stat;
	logic hit_tx;
	logic hit_rx;
	logic mapped;
	logic wr_acc;
	logic idle;

	// decode and zero wait state answer
	assign widx = paddr[9:2];
	assign bsel = paddr[4:2];
	assign hit_cmd = (paddr[11:10] == 2'b00) && (widx == `UFB_H_IDX_CMD);
	assign hit_stat = (paddr[11:10] == 2'b00) && (widx == `UFB_H_IDX_STAT);
	assign hit_tx = (paddr[11:10] == 2'b00) && ({widx[7:3], 3'b000} == `UFB_H_IDX_TX);
	assign hit_rx = (paddr[11:10] == 2'b00) && ({widx[7:3], 3'b000} == `UFB_H_IDX_RX);
	assign mapped = hit_cmd | hit_stat | hit_tx | hit_rx;
	assign wr_acc = psel & penable & pwrite & mapped;
	assign pready = psel & penable;
	assign pslverr = psel & penable & ~mapped;
	assign prdata = prdata_q;
	assign idle = (state_q == ufb_pkg::HT_IDLE);

	// status: busy in bit 0, result in bits 2:1, last byte count in 6:4
	always_comb begin
		rd_mux = '0;
		if (hit_stat) begin
			rd_mux[6:0] = {cnt_q, 1'b0, res_q, ~idle};
		end else if (hit_tx) begin
			rd_mux[7:0] = tx_buf_q[bsel];
		end else if (hit_rx) begin
			rd_mux[7:0] = rx_buf_q[bsel];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= '0;
		end else if (psel && !penable && !pwrite) begin
			prdata_q <= rd_mux;
		end
	end

	// data buffers, no reset needed
	always_ff @(posedge pclk) begin
		if (wr_acc && hit_tx) begin
			tx_buf_q[bsel] <= pwdata[7:0];
		end
		if (state_q == ufb_pkg::HT_RECV && link.dd_valid) begin
			rx_buf_q[cnt_q] <= link.dd_data;
		end
	end

	// sequencer; commands while busy are dropped
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= ufb_pkg::HT_IDLE;
			pid_q <= ufb_pkg::PID_OUT;
			ep_q <= '0;
			cnt_q <= '0;
			res_q <= ufb_pkg::RES_NONE;
		end else begin
			case (state_q)
				ufb_pkg::HT_IDLE: begin
					if (wr_acc && hit_cmd && pwdata[`UFB_CMD_RESUME]) begin
						state_q <= ufb_pkg::HT_RES;
					end else if (wr_acc && hit_cmd && pwdata[`UFB_CMD_GO]) begin
						pid_q <= ufb_pkg::ufb_pid_t'(pwdata[`UFB_CMD_PID]);
						ep_q <= pwdata[`UFB_CMD_EP];
						cnt_q <= '0;
						res_q <= ufb_pkg::RES_NONE;
						state_q <= ufb_pkg::HT_TOK;
					end
				end
				ufb_pkg::HT_TOK: begin
					state_q <= (pid_q == ufb_pkg::PID_IN) ? ufb_pkg::HT_RECV : ufb_pkg::HT_SEND;
				end
				ufb_pkg::HT_SEND: begin
					cnt_q <= cnt_q + 3'h1;
					if (cnt_q == `UFB_LAST_BYTE) begin
						state_q <= ufb_pkg::HT_WHS;
					end
				end
				ufb_pkg::HT_WHS: begin
					if (link.hs_valid) begin
						res_q <= (link.hs_code == ufb_pkg::HSK_ACK) ? ufb_pkg::RES_ACK : ufb_pkg::RES_NAK;
						state_q <= ufb_pkg::HT_IDLE;
					end
				end
				ufb_pkg::HT_RECV: begin
					if (link.hs_valid) begin
						res_q <= ufb_pkg::RES_NAK;
						state_q <= ufb_pkg::HT_IDLE;
					end else if (link.dd_valid) begin
						cnt_q <= cnt_q + 3'h1;
						if (link.dd_last) begin
							state_q <= ufb_pkg::HT_ACK;
						end
					end
				end
				ufb_pkg::HT_ACK: begin
					res_q <= ufb_pkg::RES_DATA;
					state_q <= ufb_pkg::HT_IDLE;
				end
				default: begin
					state_q <= ufb_pkg::HT_IDLE;
				end
			endcase
		end
	end

	// out data byte registered one step ahead of the counter
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hd_data_q <= '0;
		end else if (state_q == ufb_pkg::HT_SEND) begin
			hd_data_q <= tx_buf_q[cnt_q + 3'h1];
		end else begin
			hd_data_q <= tx_buf_q[0];
		end
	end

	assign link.tok_valid = (state_q == ufb_pkg::HT_TOK);
	assign link.tok_pid = pid_q;
	assign link.tok_ep = ep_q;
	assign link.hd_valid = (state_q == ufb_pkg::HT_SEND);
	assign link.hd_data = hd_data_q;
	assign link.hd_last = (state_q == ufb_pkg::HT_SEND) && (cnt_q == `UFB_LAST_BYTE);
	assign link.hh_ack = (state_q == ufb_pkg::HT_ACK);
	assign link.bus_act = (state_q == ufb_pkg::HT_TOK) || (state_q == ufb_pkg::HT_RES);
endmodule

// ### logic/ufb_link_if.sv
// token level usb link joining the host controller and the function
`timescale 1ns/100ps
interface ufb_link_if;
	// host to function
	logic tok_valid;
	ufb_pkg::ufb_pid_t tok_pid;
	logic [1:0] tok_ep;
	logic hd_valid;
	logic [7:0] hd_data;
	logic hd_last;
	logic hh_ack;
	logic bus_act;
	// function to host
	logic dd_valid;
	logic [7:0] dd_data;
	logic dd_last;
	logic hs_valid;
	ufb_pkg::ufb_hs_t hs_code;

	modport dev (
		input tok_valid, tok_pid, tok_ep, hd_valid, hd_data, hd_last, hh_ack, bus_act,
		output dd_valid, dd_data, dd_last, hs_valid, hs_code
	);
	modport host (
		output tok_valid, tok_pid, tok_ep, hd_valid, hd_data, hd_last, hh_ack, bus_act,
		input dd_valid, dd_data, dd_last, hs_valid, hs_code
	);
endinterface

// ### logic/ufb_pkg.sv
// shared types for the usb endpoint logic and its host controller
package ufb_pkg;
	typedef enum logic [1:0] {PID_OUT, PID_IN, PID_SETUP} ufb_pid_t;
	typedef enum logic {HSK_ACK, HSK_NAK} ufb_hs_t;
	typedef enum logic [1:0] {RES_NONE, RES_ACK, RES_NAK, RES_DATA} ufb_res_t;
	typedef enum logic [2:0] {DS_IDLE, DS_RX, DS_HS, DS_TX, DS_WACK} ufb_dev_state_t;
	typedef enum logic [2:0] {HT_IDLE, HT_TOK, HT_SEND, HT_WHS, HT_RECV, HT_ACK, HT_RES} ufb_host_state_t;
endpackage

// ### tb/test_usb_endpoint_flag_buffer_logic.sv
// self-checking bench joining the function and host controller ends over apb
`timescale 1ns/100ps
`include "ufb_defines.svh"
module test_usb_endpoint_flag_buffer_logic;
	localparam logic [11:0] A_CTRL = {2'b00, `UFB_IDX_CTRL, 2'b00};
	localparam logic [11:0] A_FLG = {2'b00, `UFB_IDX_FLAGS, 2'b00};
	localparam logic [11:0] A_IEN = {2'b00, `UFB_IDX_IEN, 2'b00};
	localparam logic [11:0] A_CLR = {2'b00, `UFB_IDX_CLR, 2'b00};
	// shared apb lines, one select per slave
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel_d = 1'b0;
	logic psel_h = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] d_prdata, h_prdata;
	logic d_pready, h_pready, d_pslverr, h_pslverr, usb_irq, last_err;
	logic [31:0] r;
	int bad_count = 0;
	int checks_done = 0;

	ufb_link_if link ();
	ufb_device u_ufb_device (.pclk(pclk), .presetn(presetn), .psel(psel_d), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(d_prdata), .pready(d_pready), .pslverr(d_pslverr),
		.usb_irq(usb_irq), .link(link.dev));
	ufb_host u_ufb_host (.pclk(pclk), .presetn(presetn), .psel(psel_h), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(h_prdata), .pready(h_pready), .pslverr(h_pslverr),
		.link(link.host));
	ufb_link_props u_ufb_link_props (.pclk(pclk), .presetn(presetn), .tok_valid(link.tok_valid),
		.tok_pid(link.tok_pid), .tok_ep(link.tok_ep), .hd_valid(link.hd_valid), .hd_last(link.hd_last),
		.hh_ack(link.hh_ack), .dd_valid(link.dd_valid), .dd_last(link.dd_last), .hs_valid(link.hs_valid),
		.hs_code(link.hs_code));

	always #2 pclk = ~pclk;

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// one apb transfer; request held until pready is sampled high
	task automatic apb(input logic h, input logic wr, input logic [11:0] a, input logic [31:0] wd);
		int n;
		n = 0;
		@(posedge pclk);
		psel_d <= !h;
		psel_h <= h;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		penable <= 1'b0;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while ((h ? h_pready : d_pready) !== 1'b1 && n < 20) begin
			n++;
			@(posedge pclk);
		end
		if (n == 20) bad_count++;
		r = h ? h_prdata : d_prdata;
		last_err = d_pslverr;
		psel_d <= 1'b0;
		psel_h <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic dw(input logic [11:0] a, input logic [31:0] d);
		apb(1'b0, 1'b1, a, d);
	endtask

	task automatic dchk(input string n, input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
		apb(1'b0, 1'b0, a, 32'h0);
		chk(n, r & m, e);
	endtask

	// eight bytes, byte i holds s plus i
	task automatic fill(input logic h, input logic [11:0] base, input logic [7:0] s);
		for (int i = 0; i < 8; i++) apb(h, 1'b1, base + 12'(4 * i), {24'h0, s + 8'(i)});
	endtask

	task automatic cmp8(input string n, input logic h, input logic [11:0] base, input logic [7:0] s);
		for (int i = 0; i < 8; i++) begin
			apb(h, 1'b0, base + 12'(4 * i), 32'h0);
			chk(n, r, {24'h0, s + 8'(i)});
		end
	endtask

	// host command, then wait for idle and, unless it is a resume, compare the result code
	task automatic xact(input logic rs, input logic [1:0] ep, input logic [1:0] pid, input logic [1:0] e);
		int n;
		n = 0;
		apb(1'b1, 1'b1, 12'h000, {26'h0, rs, 1'b1, ep, pid});
		do begin
			apb(1'b1, 1'b0, 12'h004, 32'h0);
			n++;
		end while (r[0] !== 1'b0 && n < 50);
		if (n == 50) bad_count++;
		if (!rs) chk("host result", {30'h0, r[2:1]}, {30'h0, e});
	endtask

	// in path of a flagged endpoint: enable, flag, nak while flagged, clear
	task automatic run_tx(input logic [1:0] ep, input int en, input int f, input logic [11:0] base);
		fill(1'b0, base, 8'h30 + 8'(ep));
		dw(A_CTRL, 32'h0);
		xact(1'b0, ep, 2'h1, 2'h2);
		dw(A_CTRL, 32'h1 << en);
		xact(1'b0, ep, 2'h1, 2'h3);
		cmp8("in data", 1'b1, 12'h040, 8'h30 + 8'(ep));
		dchk("tx flag", A_FLG, 32'h1 << f, 32'h1 << f);
		dw(A_CTRL, 32'h1 << en);
		xact(1'b0, ep, 2'h1, 2'h2);
		dw(A_FLG, 32'h0);
		dchk("tx flag kept", A_FLG, 32'h1 << f, 32'h1 << f);
		dw(A_CLR, 32'h1 << f);
		dchk("tx flag cleared", A_FLG, 32'h1 << f, 32'h0);
		xact(1'b0, ep, 2'h1, 2'h3);
		dw(A_CLR, 32'h1f);
	endtask

	initial begin
		repeat (20000) @(posedge pclk);
		bad_count++;
		report_and_stop();
	end

	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		dchk("flags reset", A_FLG, 32'hffff_ffff, 32'h0);
		dchk("ctrl reset", A_CTRL, 32'hffff_ffff, 32'h0);
		dchk("unmapped read", 12'h400, 32'hffff_ffff, 32'h0);
		chk("unmapped error", {31'h0, last_err}, 32'h1);
		// ep0: in sends the tx buffer, out and setup fill the rx buffer
		fill(1'b0, 12'h080, 8'ha0);
		xact(1'b0, 2'h0, 2'h1, 2'h3);
		cmp8("ep0 in data", 1'b1, 12'h040, 8'ha0);
		dchk("ep0 tx flag", A_FLG, 32'h1, 32'h1);
		for (int p = 0; p < 3; p += 2) begin
			fill(1'b1, 12'h020, 8'h50 + 8'(p));
			xact(1'b0, 2'h0, 2'(p), 2'h1);
			cmp8("ep0 rx data", 1'b0, 12'h080, 8'h50 + 8'(p));
		end
		dw(A_CLR, 32'h1f);
		dchk("ep1 write only", 12'h0a0, 32'hffff_ffff, 32'h0);
		run_tx(2'h1, 0, 1, 12'h0a0);
		run_tx(2'h2, 1, 2, 12'h0c0);
		xact(1'b0, 2'h3, 2'h1, 2'h2);
		// ep2 out: refused without enable, flag, nak while flagged
		fill(1'b1, 12'h020, 8'h70);
		xact(1'b0, 2'h2, 2'h0, 2'h2);
		dw(A_CTRL, 32'h4);
		xact(1'b0, 2'h2, 2'h0, 2'h1);
		dchk("rx flag", A_FLG, 32'h8, 32'h8);
		dchk("rx enable spent", A_CTRL, 32'h4, 32'h0);
		cmp8("ep2 rx data", 1'b0, 12'h0c0, 8'h70);
		dw(A_CTRL, 32'h4);
		xact(1'b0, 2'h2, 2'h0, 2'h2);
		dw(A_FLG, 32'h0);
		dchk("rx flag kept", A_FLG, 32'h8, 32'h8);
		dw(A_CLR, 32'h8);
		dchk("rx flag cleared", A_FLG, 32'h8, 32'h0);
		xact(1'b0, 2'h2, 2'h0, 2'h1);
		dw(A_CLR, 32'h1f);
		// resume only while suspended, sticky until its clear bit
		xact(1'b1, 2'h0, 2'h0, 2'h0);
		dchk("no resume awake", A_FLG, 32'h10, 32'h0);
		dw(A_CTRL, 32'h8);
		dw(A_IEN, 32'h10);
		xact(1'b1, 2'h0, 2'h0, 2'h0);
		dchk("resume flag", A_FLG, 32'h10, 32'h10);
		chk("irq on", {31'h0, usb_irq}, 32'h1);
		dw(A_FLG, 32'h0);
		dchk("resume kept", A_FLG, 32'h10, 32'h10);
		dw(A_IEN, 32'h0);
		// the request register follows the enable one edge late
		repeat (2) @(posedge pclk);
		chk("irq masked", {31'h0, usb_irq}, 32'h0);
		dw(A_CTRL, 32'h0);
		dw(A_CLR, 32'h10);
		dchk("resume cleared", A_FLG, 32'h10, 32'h0);
		report_and_stop();
	end
endmodule

// ### tb/ufb_link_props.sv
// link protocol checker for the usb endpoint logic, fed by the link interface signals
`timescale 1ns/100ps
module ufb_link_props (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// host to function
	input wire logic tok_valid,
	input wire ufb_pkg::ufb_pid_t tok_pid,
	input wire logic [1:0] tok_ep,
	input wire logic hd_valid,
	input wire logic hd_last,
	input wire logic hh_ack,
	// function to host
	input wire logic dd_valid,
	input wire logic dd_last,
	input wire logic hs_valid,
	input wire ufb_pkg::ufb_hs_t hs_code
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// eight consecutive data bytes, last marked on the eighth
	sequence s_burst;
		(dd_valid && !dd_last)[*7] ##1 (dd_valid && dd_last);
	endsequence
	sequence s_nak;
		hs_valid && hs_code == ufb_pkg::HSK_NAK;
	endsequence

	property p_burst;
		$rose(dd_valid) |-> s_burst;
	endproperty
	a_burst: assert property (p_burst) else $error("in packet not eight bytes");
	property p_burst_end;
		dd_valid && dd_last |=> !dd_valid;
	endproperty
	a_burst_end: assert property (p_burst_end) else $error("data after last byte");
	// an in token gets either a nak or a full packet, nothing else
	property p_in_answer;
		tok_valid && tok_pid == ufb_pkg::PID_IN |-> (##1 s_nak) or (##2 s_burst);
	endproperty
	a_in_answer: assert property (p_in_answer) else $error("in token badly answered");
	// endpoint 0 never refuses an in token
	property p_ep0_in;
		tok_valid && tok_pid == ufb_pkg::PID_IN && tok_ep == 2'h0 |-> ##2 s_burst;
	endproperty
	a_ep0_in: assert property (p_ep0_in) else $error("ep0 in not answered with data");
	property p_ep0_out;
		tok_valid && tok_pid != ufb_pkg::PID_IN && tok_ep == 2'h0
			|-> ##8 (hd_valid && hd_last) ##1 (hs_valid && hs_code == ufb_pkg::HSK_ACK);
	endproperty
	a_ep0_out: assert property (p_ep0_out) else $error("ep0 out or setup not acked");
	property p_out_hs;
		hd_valid && hd_last |=> hs_valid;
	endproperty
	a_out_hs: assert property (p_out_hs) else $error("no handshake after out data");
	property p_ep3_nak;
		tok_valid && tok_pid == ufb_pkg::PID_IN && tok_ep == 2'h3 |-> ##1 s_nak;
	endproperty
	a_ep3_nak: assert property (p_ep3_nak) else $error("unused endpoint not refused");
	property p_hs_pulse;
		hs_valid |=> !hs_valid;
	endproperty
	a_hs_pulse: assert property (p_hs_pulse) else $error("handshake longer than one cycle");
	property p_host_ack;
		dd_valid && dd_last |=> hh_ack;
	endproperty
	a_host_ack: assert property (p_host_ack) else $error("host did not ack in data");
	c_nak: cover property (s_nak);
endmodule
